// ==== rtl/current_sensor_end.sv ====
/*
 Sensor end: integrates the input over each carrier half period, encodes the
 result as an active-low duty cycle, and debounces and latches over-current.
 Assumes the link arrives through phase_sense_if and the analog input is
 already a digital mV value on the system clock.
*/
// How it works
// - Carrier timing input is the only sequencer
// - Pulse output only pulls low
// - Controller decodes high time over period
// - Duty held between 10% and 30%
// - Duty falls 40 percent per volt
// - High half channel 1, low half channel 2
// - Each half period measured on its own
// - Controller compensates each channel separately
// - Fault flag only pulls low
// - Continuous excess past debounce latches fault
// - Pulse held low clears latched fault
// - Latched fault releases pulse output
// - Persistent fault re-latches on next timing edge
// - Fault wired to pulse self-clears
// - Timing period resets the input integrator
// - Integrator sampled on both timing edges
// - Quarter-period shifted timing optional
// - Aligned timing with pairwise averaging optional
// - Half-frequency timing for centre PWM
// - Debounce interval 2.7 to 4.7 us
// - 0.5 us low clears fault
// - Range straps chosen by carrier frequency
`timescale 1ns/10ps
`default_nettype none
`include "phase_sense_regs.svh"
module current_sensor_end (
   // System
   input  wire logic                       clock,
   input  wire logic                       sys_rst,
   // Link
   phase_sense_if.sensor                   link,
   // Analog side, already digitised
   input  wire phase_sense_pkg::mv_t       senseMv,
   input  wire phase_sense_pkg::mv_t       overcurrentThreshold,
   input  wire logic                       filterRangeSelLow,
   input  wire logic                       filterRangeSelHigh,
   // Status
   output logic                            sampleValid,
   output phase_sense_pkg::duty_t          sampleDuty,
   output logic                            sampleChannel
);
   logic        timSync1;      // First synchroniser stage
   logic        timSync2;      // Second stage, safe to read
   logic        timPrev;       // Delayed for edge detection
   logic        pulSync1;      // Pulse line first stage
   logic        pulSync2;      // Pulse line second stage
   logic        tEdge;         // Any timing edge
   logic        tRise;         // Rising timing edge
   logic signed [31:0] accQ;   // Input integrator
   logic [`CNT_W-1:0]  halfCntQ; // Length of current half period
   logic [`CNT_W-1:0]  lastHalfQ; // Length of previous half period
   logic signed [31:0] avgMv;  // Mean input over the half period
   logic signed [31:0] dutyRaw; // Unclamped duty code
   phase_sense_pkg::duty_t dutyClamp; // Clamped duty code
   // Two-entry buffer between encoder and pulse generator
   phase_sense_pkg::duty_t bufQ [2];
   logic [1:0]  wrPtrQ;        // Write pointer with wrap bit
   logic [1:0]  rdPtrQ;        // Read pointer with wrap bit
   logic        bufFull;       // Both entries taken
   logic        bufEmpty;      // No entry waiting
   logic        inValid;       // Encoder offers a word
   logic        inReady;       // Buffer accepts it
   logic        outReady;      // Pulse generator takes one
   logic [`CNT_W-1:0] lowCntQ; // Remaining low time of current pulse
   phase_sense_pkg::duty_t curDutyQ; // Duty being played
   logic        driveLowQ;     // Pulse pull-down enable
   phase_sense_pkg::fault_e fltQ; // Fault state
   logic [`CNT_W-1:0] debCntQ; // Debounce counter
   logic [`CNT_W-1:0] clrCntQ; // Low-level counter on pulse line
   logic        overNow;       // Magnitude above threshold
   logic        faultLowQ;     // Fault pull-down enable
   logic        waitEdgeQ;     // Cleared while still over: re-latch at edge

   // Synchronise both link lines into the clock domain
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         timSync1 <= 1'B0;
         timSync2 <= 1'B0;
         timPrev  <= 1'B0;
         pulSync1 <= 1'B1;
         pulSync2 <= 1'B1;
      end else begin
         timSync1 <= link.timingIn;
         timSync2 <= timSync1;
         timPrev  <= timSync2;
         pulSync1 <= link.pulseLevel;
         pulSync2 <= pulSync1;
      end
   end
   assign tEdge = timSync2 ^ timPrev;
   assign tRise = timSync2 & ~timPrev;

   // Integrator reset on every timing edge; each half is its own channel
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         accQ      <= 32'SH0;
         halfCntQ  <= '0;
         lastHalfQ <= '0;
      end else if (tEdge) begin
         accQ      <= 32'(senseMv);
         halfCntQ  <= `CNT_W'(1);
         lastHalfQ <= halfCntQ;
      end else begin
         accQ     <= accQ + 32'(senseMv);
         halfCntQ <= halfCntQ + `CNT_W'(1);
      end
   end

   // Range straps only scale the analog integrator; unused here, sunk into unusedStraps
   logic unusedStraps;
   assign unusedStraps = filterRangeSelLow ^ filterRangeSelHigh;

   // Encode the mean input as a duty code in per mille
   always_comb begin
      avgMv   = (halfCntQ == '0) ? 32'SH0 : accQ / $signed({16'H0, halfCntQ});
      // Signed throughout, so a negative input is not divided as unsigned
      dutyRaw = $signed(32'(`DUTY_MID)) - (avgMv * `GAIN_NUM) / `GAIN_DEN;
      if (dutyRaw < $signed(32'(`DUTY_MIN)))
         dutyClamp = `DUTY_MIN;
      else if (dutyRaw > $signed(32'(`DUTY_MAX)))
         dutyClamp = `DUTY_MAX;
      else
         dutyClamp = dutyRaw[9:0];
   end
   assign inValid = tEdge;

   // Status outputs: the sample closed at this edge and its channel
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sampleValid   <= 1'B0;
         sampleDuty    <= `DUTY_MID;
         sampleChannel <= 1'B0;
      end else begin
         sampleValid <= tEdge && inReady;
         if (tEdge) begin
            sampleDuty    <= dutyClamp;
            sampleChannel <= tRise; // falling edge closes channel 1 (0)
         end
      end
   end

   // Two-entry buffer; a word is read at every edge, so words read while a fault blocks the pulse generator are dropped
   assign bufFull  = (wrPtrQ[0] == rdPtrQ[0]) && (wrPtrQ[1] != rdPtrQ[1]);
   assign bufEmpty = (wrPtrQ == rdPtrQ);
   assign inReady  = !bufFull;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wrPtrQ <= 2'H0;
         rdPtrQ <= 2'H0;
         bufQ[0] <= `DUTY_MID;
         bufQ[1] <= `DUTY_MID;
      end else begin
         if (inValid && inReady) begin
            bufQ[wrPtrQ[0]] <= dutyClamp;
            wrPtrQ <= wrPtrQ + 2'H1;
         end
         if (outReady && !bufEmpty)
            rdPtrQ <= rdPtrQ + 2'H1;
      end
   end

   // Pulse generator: at each edge, pull low for (1000 - duty) per mille of last half
   assign outReady = tEdge;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lowCntQ   <= '0;
         curDutyQ  <= `DUTY_MID;
         driveLowQ <= 1'B0;
      end else if (faultLowQ) begin
         // Latched fault aborts the pulse; drive resumes only at a fresh edge
         lowCntQ   <= '0;
         driveLowQ <= 1'B0;
      end else if (outReady && !bufEmpty) begin
         curDutyQ  <= bufQ[rdPtrQ[0]];
         lowCntQ   <= `CNT_W'((32'(lastHalfQ) * 32'(1000 - bufQ[rdPtrQ[0]])) / 1000);
         driveLowQ <= 1'B1;
      end else if (lowCntQ != '0) begin
         lowCntQ   <= lowCntQ - `CNT_W'(1);
         driveLowQ <= (lowCntQ > `CNT_W'(1));
      end else begin
         driveLowQ <= 1'B0;
      end
   end
   // Fault releases the pulse line; open-drain: enable only, never high
   assign link.pulseOutEn = driveLowQ && !faultLowQ;

   // Over-current detection on magnitude
   assign overNow = (senseMv < 0 ? -senseMv : senseMv) > overcurrentThreshold;

   // Fault state: debounce, latch, clear by held-low pulse line
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fltQ      <= phase_sense_pkg::FLT_IDLE;
         debCntQ   <= '0;
         clrCntQ   <= '0;
         faultLowQ <= 1'B0;
         waitEdgeQ <= 1'B0;
      end else begin
         unique case (fltQ)
            phase_sense_pkg::FLT_IDLE: begin
               if (waitEdgeQ && overNow) begin
                  if (tEdge) begin
                     fltQ      <= phase_sense_pkg::FLT_LATCH;
                     faultLowQ <= 1'B1;
                     waitEdgeQ <= 1'B0;
                  end
               end else begin
                  waitEdgeQ <= 1'B0;
                  if (overNow) begin
                     fltQ    <= phase_sense_pkg::FLT_DEBNC;
                     debCntQ <= `CNT_W'(1);
                  end
               end
            end
            phase_sense_pkg::FLT_DEBNC: begin
               if (!overNow) begin
                  fltQ <= phase_sense_pkg::FLT_IDLE;
               end else if (debCntQ >= `CNT_W'(`DEBOUNCE_CYC)) begin
                  fltQ      <= phase_sense_pkg::FLT_LATCH;
                  faultLowQ <= 1'B1;
                  clrCntQ   <= '0;
               end else begin
                  debCntQ <= debCntQ + `CNT_W'(1);
               end
            end
            phase_sense_pkg::FLT_LATCH: begin
               // Sensor no longer drives pulse, so a low here is the controller's or the strapped fault flag's
               if (!pulSync2) begin
                  if (clrCntQ >= `CNT_W'(`CLEAR_CYC - 1)) begin
                     fltQ      <= phase_sense_pkg::FLT_IDLE;
                     faultLowQ <= 1'B0;
                     waitEdgeQ <= overNow;
                     clrCntQ   <= '0;
                  end else begin
                     clrCntQ <= clrCntQ + `CNT_W'(1);
                  end
               end else begin
                  clrCntQ <= '0;
               end
            end
         endcase
      end
   end
   assign link.faultOutEn = faultLowQ;
endmodule
`default_nettype wire

// ==== rtl/phase_sense_regs.svh ====
/*
 Timing and encoding constants shared by the device end and the controller end.
 Assumes a 50 MHz system clock; included by bare name.
*/
`ifndef PHASE_SENSE_REGS_SVH
`define PHASE_SENSE_REGS_SVH
// System clock rate in kHz
`define CLK_KHZ            50000
// Debounce time in ns, figure as given (2.7 to 4.7 us, typ 3.5)
`define DEBOUNCE_NS        3500
// Debounce typical time rounds up to whole cycles
`define DEBOUNCE_CYC       ((`DEBOUNCE_NS * (`CLK_KHZ / 1000) + 999) / 1000)
// Fault clear pulse time in ns, at most 0.5 us
`define CLEAR_NS           500
// Longest time rounds down
`define CLEAR_CYC          ((`CLEAR_NS * (`CLK_KHZ / 1000)) / 1000)
// Duty codes in per mille: 10%, 20% midpoint, 30%
`define DUTY_MIN           10'D100
`define DUTY_MID           10'D200
`define DUTY_MAX           10'D300
// Gain 40 %/V gives 0.4 per mille per mV; input in mV
`define GAIN_NUM           4
`define GAIN_DEN           10
// Half-period counter width
`define CNT_W              16
`endif

// ==== rtl/phase_sense_pkg.sv ====
/*
 Types shared by both ends of the phase current link.
 Assumes the constants header is compiled alongside.
*/
package phase_sense_pkg;
   typedef logic signed [11:0] mv_t;   // Differential input, mV
   typedef logic [9:0]         duty_t; // Duty in per mille
   typedef logic [15:0]        cnt_t;  // Cycle counts
   typedef enum logic [2:0] {
      FLT_IDLE  = 3'B001,
      FLT_DEBNC = 3'B010,
      FLT_LATCH = 3'B100
   } fault_e;
endpackage

// ==== rtl/phase_sense_if.sv ====
/*
 Link between the sensor end and the controller end: one timing line driven by
 the controller, two open-drain lines resolved here from their enables.
 Assumes an external pull-up on both open-drain lines.
*/
`timescale 1ns/10ps
`default_nettype none
interface phase_sense_if;
   logic timingIn;       // Carrier timing, from controller
   logic pulseOutEn;     // Sensor pulls pulse line low
   logic pulseForceEn;   // Controller pulls pulse line low
   logic faultOutEn;     // Sensor pulls fault line low
   logic flagTiedToPulse; // Board option: fault wired onto pulse line
   logic pulseLevel;     // Resolved pulse line level
   logic faultLevel;     // Resolved fault line level
   // Wired-AND with pull-up; optional strap ties the two lines together
   assign faultLevel = !(faultOutEn || (flagTiedToPulse && (pulseOutEn || pulseForceEn)));
   assign pulseLevel = !(pulseOutEn || pulseForceEn || (flagTiedToPulse && faultOutEn));
   modport sensor (input timingIn, input pulseLevel, output pulseOutEn, output faultOutEn);
   modport ctrl   (output timingIn, output pulseForceEn, input pulseLevel,
                   input faultLevel);
endinterface
`default_nettype wire

// ==== rtl/motor_ctrl_end.sv ====
/*
 Controller end: drives the carrier timing line from a divider, measures
 high time of the pulse line against its own divider half period, decodes duty per channel with
 separate offsets, and can force the pulse line low to clear a fault.
 Assumes the link arrives through phase_sense_if.
*/
`timescale 1ns/10ps
`default_nettype none
`include "phase_sense_regs.svh"
module motor_ctrl_end (
   // System
   input  wire logic                       clock,
   input  wire logic                       sys_rst,
   // Link
   phase_sense_if.ctrl                     link,
   // User control
   input  wire logic [`CNT_W-1:0]          halfPeriodCyc,
   input  wire logic                       clearFaultReq,
   input  wire logic signed [9:0]          offsetCh1,
   input  wire logic signed [9:0]          offsetCh2,
   // Results
   output logic                            dutyValid,
   output phase_sense_pkg::duty_t          dutyOut,
   output logic                            dutyChannel,
   output logic                            faultSeen
);
   logic [`CNT_W-1:0] divQ;    // Half-period divider
   logic        timQ;          // Timing line level
   logic        pSync1;        // Pulse line first stage
   logic        pSync2;        // Pulse line second stage
   logic        pPrev;         // For edge detection
   logic        fSync1;        // Fault line first stage
   logic        fSync2;        // Fault line second stage
   logic [`CNT_W-1:0] highCntQ; // High time since last rise
   logic [`CNT_W-1:0] perCntQ;  // Cycles in current half
   logic [`CNT_W-1:0] prevPerQ; // Length of previous half
   logic [`CNT_W-1:0] clrCntQ;  // Force-low counter
   logic        forceQ;        // Pull pulse line low
   logic        halfEdge;      // Divider wrap

   // Timing line from a divider, toggled each half period
   assign halfEdge = (divQ >= halfPeriodCyc - `CNT_W'(1));
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         divQ <= '0;
         timQ <= 1'B0;
      end else if (halfEdge) begin
         divQ <= '0;
         timQ <= !timQ;
      end else begin
         divQ <= divQ + `CNT_W'(1);
      end
   end
   assign link.timingIn = timQ;

   // Synchronise the open-drain lines
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pSync1 <= 1'B1;
         pSync2 <= 1'B1;
         pPrev  <= 1'B1;
         fSync1 <= 1'B1;
         fSync2 <= 1'B1;
      end else begin
         pSync1 <= link.pulseLevel;
         pSync2 <= pSync1;
         pPrev  <= pSync2;
         fSync1 <= link.faultLevel;
         fSync2 <= fSync1;
      end
   end

   // Decode: high time of the pulse just ended over the length of the half just ended
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         highCntQ    <= '0;
         perCntQ     <= '0;
         prevPerQ    <= '0;
         dutyValid   <= 1'B0;
         dutyOut     <= `DUTY_MID;
         dutyChannel <= 1'B0;
      end else begin
         dutyValid <= 1'B0;
         perCntQ   <= halfEdge ? '0 : perCntQ + `CNT_W'(1);
         if (halfEdge)
            prevPerQ <= perCntQ + `CNT_W'(1);
         if (pSync2 && !pPrev)
            highCntQ <= `CNT_W'(1); // Rising cycle itself is high time
         else if (pSync2)
            highCntQ <= highCntQ + `CNT_W'(1);
         // Falling pulse edge ends a high interval
         if (!pSync2 && pPrev && prevPerQ != '0 && !forceQ) begin
            dutyValid   <= 1'B1;
            dutyChannel <= timQ; // Low timing at decode: channel 1 (0)
            dutyOut     <= 10'((32'(highCntQ) * 1000) / 32'(prevPerQ)
                           - 32'(timQ ? offsetCh2 : offsetCh1));
         end
      end
   end

   // Fault clear: hold the pulse line low for the clear time plus three cycles
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         forceQ  <= 1'B0;
         clrCntQ <= '0;
      end else if (forceQ) begin
         if (clrCntQ >= `CNT_W'(`CLEAR_CYC + 2)) begin
            forceQ <= 1'B0;
         end
         clrCntQ <= clrCntQ + `CNT_W'(1);
      end else if (clearFaultReq) begin
         forceQ  <= 1'B1;
         clrCntQ <= '0;
      end
   end
   assign link.pulseForceEn = forceQ;

   // Fault level seen by the controller
   always_ff @(posedge clock) begin
      if (sys_rst)
         faultSeen <= 1'B0;
      else
         faultSeen <= !fSync2;
   end
endmodule
`default_nettype wire

// ==== tb/phase_sense_monitor.sv ====
/*
 Checker for the phase current link: carrier line, open-drain enables, levels.
 Assumes one clock and that the testbench instantiates it beside the link.
*/
`timescale 1ns/10ps
`default_nettype none
`include "phase_sense_regs.svh"
module phase_sense_monitor (
   // System
   input wire logic clock,
   input wire logic sys_rst,
   // Link
   input wire logic timingIn,
   input wire logic pulseOutEn,
   input wire logic pulseForceEn,
   input wire logic faultOutEn,
   input wire logic flagTiedToPulse,
   input wire logic pulseLevel,
   input wire logic faultLevel
);
   logic [15:0] halfCnt_q;  // Cycles since the last carrier edge
   logic [15:0] prevHalf_q; // Length of the last whole half
   logic [1:0]  edges_q;    // Edges seen, saturating at three
   logic        timingD_q;  // Carrier line one cycle back
   logic [15:0] driveCnt_q; // Cycles the pulse line has been pulled
   logic [7:0]  lowRun_q;   // Cycles latched with the pulse line low
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Half-period meter; first halves after reset are partial, so gated
   always_ff @(posedge clock) begin
      timingD_q <= timingIn;
      if (sys_rst) begin
         halfCnt_q  <= 16'H0001;
         prevHalf_q <= 16'H0000;
         edges_q    <= 2'H0;
      end else if (timingIn != timingD_q) begin
         halfCnt_q  <= 16'H0001;
         prevHalf_q <= halfCnt_q;
         edges_q    <= (edges_q == 2'H3) ? edges_q : edges_q + 2'H1;
      end else begin
         halfCnt_q  <= halfCnt_q + 16'H0001;
      end
   end
   // Length of the current pulse drive
   always_ff @(posedge clock) begin
      if (sys_rst || !pulseOutEn) driveCnt_q <= 16'H0000;
      else driveCnt_q <= driveCnt_q + 16'H0001;
   end
   // Clear pulse length while latched; saturates to avoid wrap
   always_ff @(posedge clock) begin
      if (sys_rst || !faultOutEn || pulseLevel) lowRun_q <= 8'H00;
      else if (lowRun_q != 8'HFF) lowRun_q <= lowRun_q + 8'H01;
   end
   sequence s_edge;
      timingIn != $past(timingIn);
   endsequence
   sequence s_tied_latch;
      $rose(faultOutEn) ##0 flagTiedToPulse;
   endsequence
   property p_pulse_start;
      $rose(pulseOutEn) |-> $past(timingIn, 3) != $past(timingIn, 6);
   endproperty
   property p_edge_drive;
      s_edge ##0 (edges_q == 2'H3 && !faultOutEn) |-> ##[3:6] (pulseOutEn || faultOutEn);
   endproperty
   property p_duty_span;
      $fell(pulseOutEn) && !faultOutEn && !$past(faultOutEn) && edges_q == 2'H3
         |-> 32'(driveCnt_q) * 10 + 10 >= 32'(prevHalf_q) * 7
          && 32'(driveCnt_q) * 10 <= 32'(prevHalf_q) * 9 + 10;
   endproperty
   property p_timing_steady;
      s_edge ##0 (edges_q == 2'H3) |-> halfCnt_q == prevHalf_q;
   endproperty
   property p_latch_hold;
      $rose(faultOutEn) |-> faultOutEn [*8];
   endproperty
   property p_fault_release;
      faultOutEn && $past(faultOutEn) |-> !pulseOutEn;
   endproperty
   property p_clear_min;
      $fell(faultOutEn) |-> lowRun_q >= `CLEAR_CYC;
   endproperty
   property p_clear_bound;
      lowRun_q <= `CLEAR_CYC + 6;
   endproperty
   property p_auto_clear;
      s_tied_latch |-> ##[1:40] !faultOutEn;
   endproperty
   a_pulse_start: assert property (p_pulse_start)
      else $error("pulse drive began away from a carrier edge");
   a_edge_drive: assert property (p_edge_drive)
      else $error("no pulse drive after a carrier edge");
   a_duty_span: assert property (p_duty_span)
      else $error("pulse drive length outside the duty span");
   a_timing_steady: assert property (p_timing_steady)
      else $error("carrier half period changed");
   a_latch_hold: assert property (p_latch_hold)
      else $error("fault flag did not stay latched");
   a_fault_release: assert property (p_fault_release)
      else $error("pulse driven while fault latched");
   a_clear_min: assert property (p_clear_min)
      else $error("fault cleared by a short low");
   a_clear_bound: assert property (p_clear_bound)
      else $error("fault not cleared by a long low");
   a_auto_clear: assert property (p_auto_clear)
      else $error("tied fault flag did not clear itself");
endmodule
`default_nettype wire

// ==== tb/phase_current_pwm_encoder_oc_latch_test.sv ====
/*
 Testbench: sensor end and controller end joined by the link, checker beside.
 Assumes the design package, header and link interface are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module phase_current_pwm_encoder_oc_latch_test;
   logic                   clock;        // 50 MHz
   logic                   sys_rst;      // Synchronous reset
   phase_sense_pkg::mv_t   senseMv;      // Sense input, mV
   phase_sense_pkg::mv_t   thresholdMv;  // Over-current level, mV
   logic [15:0]            halfPeriodCyc;
   logic                   clearFaultReq;
   logic signed [9:0]      offsetCh1;
   logic signed [9:0]      offsetCh2;
   logic                   sampleValid;
   phase_sense_pkg::duty_t sampleDuty;
   logic                   sampleChannel;
   logic                   dutyValid;
   phase_sense_pkg::duty_t dutyOut;
   logic                   dutyChannel;
   logic                   faultSeen;
   int                     errors;
   int                     checked;
   phase_sense_if link();
   current_sensor_end current_sensor_end_inst (.clock(clock), .sys_rst(sys_rst), .link(link),
      .senseMv(senseMv), .overcurrentThreshold(thresholdMv), .filterRangeSelLow(1'B1),
      .filterRangeSelHigh(1'B1), .sampleValid(sampleValid), .sampleDuty(sampleDuty),
      .sampleChannel(sampleChannel));
   motor_ctrl_end motor_ctrl_end_inst (.clock(clock), .sys_rst(sys_rst), .link(link),
      .halfPeriodCyc(halfPeriodCyc), .clearFaultReq(clearFaultReq), .offsetCh1(offsetCh1),
      .offsetCh2(offsetCh2), .dutyValid(dutyValid), .dutyOut(dutyOut),
      .dutyChannel(dutyChannel), .faultSeen(faultSeen));
   phase_sense_monitor monitor_inst (.clock(clock), .sys_rst(sys_rst),
      .timingIn(link.timingIn), .pulseOutEn(link.pulseOutEn),
      .pulseForceEn(link.pulseForceEn), .faultOutEn(link.faultOutEn),
      .flagTiedToPulse(link.flagTiedToPulse), .pulseLevel(link.pulseLevel),
      .faultLevel(link.faultLevel));
   // Clock generator
   initial begin
      clock = 1'B0;
      forever #10 clock = ~clock;
   end
   // Compare and count
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %0d seen %0d", name, exp, seen);
      end
   endtask
   // Pick a status output: 0 sample valid, 1 decode valid, 2 fault seen
   function automatic logic pick(int k);
      return k == 0 ? sampleValid : (k == 1 ? dutyValid : faultSeen);
   endfunction
   // Bounded wait at falling edges, so pulses are seen settled
   task automatic wait_for(int k, logic lvl, int lim);
      int n;
      n = 0;
      @(negedge clock);
      while (pick(k) !== lvl && n < lim) begin
         @(negedge clock);
         n++;
      end
      check("wait bound", n < lim, 1);
   endtask
   // Controller's clear request, one cycle wide
   task automatic clear_fault();
      clearFaultReq = 1'B1;
      @(negedge clock);
      clearFaultReq = 1'B0;
      wait_for(2, 1'B0, 60);
   endtask
   // Encoding, channels, wire duty and per-channel decode over a table of inputs
   task automatic t_gain();
      int mv[6] = '{0, 250, -250, 100, 400, -400};
      int ex;
      int lo;
      int a;
      int hi;
      logic ch;
      foreach (mv[i]) begin
         ex = 200 - mv[i] * 4 / 10;
         ex = ex < 100 ? 100 : (ex > 300 ? 300 : ex);
         wait_for(0, 1'B1, 400);
         senseMv = 12'(mv[i]);
         wait_for(0, 1'B1, 400);
         wait_for(0, 1'B1, 400);
         check("sample duty", sampleDuty, ex);
         ch = sampleChannel;
         wait_for(0, 1'B1, 400);
         check("sample duty", sampleDuty, ex);
         check("sample channel", sampleChannel, !ch);
         check("channel level", sampleChannel, link.timingIn);
         lo = 0;
         while (link.pulseLevel === 1'B0 && lo < 200) begin
            @(negedge clock);
            lo++;
         end
         check("pulse low time", lo >= 97 - ex / 10 && lo <= 103 - ex / 10, 1);
         check("fault line idle", link.faultLevel, 1);
         wait_for(1, 1'B1, 400);
         a = int'(dutyOut);
         check("decode offset", a + (dutyChannel ? 10 : 0), ex);
         wait_for(1, 1'B1, 400);
         lo = int'(dutyOut);
         check("decode offset", lo + (dutyChannel ? 10 : 0), ex);
         hi = a > lo ? a : lo;
         lo = a > lo ? lo : a;
         check("decode high", hi >= ex - 3 && hi <= ex + 3, 1);
         check("decode low", lo >= ex - 13 && lo <= ex - 7, 1);
         check("pair average", hi + lo >= 2 * ex - 13 && hi + lo <= 2 * ex - 7, 1);
      end
   endtask
   // Debounce restart, latch, pulse release, clear and re-latch
   task automatic t_fault();
      int n;
      thresholdMv = 12'H12C;
      senseMv = 12'H190;
      repeat (150) @(negedge clock);
      senseMv = 12'H000;
      repeat (3) @(negedge clock);
      senseMv = 12'H190;
      repeat (150) @(negedge clock);
      check("fault early", faultSeen, 0);
      wait_for(2, 1'B1, 60);
      n = 0;
      repeat (250) begin
         @(negedge clock);
         n += int'(link.pulseOutEn);
      end
      check("pulse drive while latched", n, 0);
      check("fault line", link.faultLevel, 0);
      clear_fault();
      n = 0;
      while (faultSeen !== 1'B1 && n < 300) begin
         @(negedge clock);
         n++;
      end
      check("re-latch delay", n <= 110, 1);
      senseMv = 12'H000;
      clear_fault();
      wait_for(0, 1'B1, 400);
      check("pulse resumes", link.pulseOutEn, 1);
   endtask
   // Fault flag strapped onto the pulse line clears itself
   task automatic t_auto();
      int n;
      logic prev;
      link.flagTiedToPulse = 1'B1;
      senseMv = 12'H190;
      n = 0;
      prev = 1'B0;
      repeat (600) begin
         @(negedge clock);
         n += int'(link.faultOutEn && !prev);
         prev = link.faultOutEn;
      end
      check("auto clear cycles", n >= 2, 1);
      senseMv = 12'H000;
      repeat (300) @(negedge clock);
      link.flagTiedToPulse = 1'B0;
      repeat (5) @(negedge clock);
      check("fault after auto clear", faultSeen, 0);
   endtask
   // Verdict
   task automatic end_sim();
      $display("Checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      errors = 0;
      checked = 0;
      sys_rst = 1'B1;
      senseMv = 12'H000;
      thresholdMv = 12'H7FF;
      halfPeriodCyc = 16'H0064;
      clearFaultReq = 1'B0;
      offsetCh1 = 10'H000;
      offsetCh2 = 10'H00A;
      link.flagTiedToPulse = 1'B0;
      repeat (6) @(negedge clock);
      check("duty at reset", sampleDuty, 200);
      check("decode at reset", dutyOut, 200);
      sys_rst = 1'B0;
      t_gain();
      t_fault();
      t_auto();
      end_sim();
   end
   // Watchdog, well beyond the expected run
   initial begin
      #1200000;
      errors++;
      end_sim();
   end
endmodule
`default_nettype wire
